/* File: common/tape_opt_pkg.sv */
// package: constants and types of the drive option parameter block
package tape_opt_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_OPTION_FLAGS = 3'h0;
  localparam logic [2:0] OFS_REGION_SEL = 3'h1;
  localparam logic [2:0] OFS_MOTION_THR = 3'h2;
  localparam logic [2:0] OFS_RECONN_THR = 3'h3;
  localparam logic [2:0] OFS_GAP_THR = 3'h4;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_CART_TYPE = 7;
  localparam int BIT_HOLD_CONN = 5;
  localparam int BIT_BUSY_SUPP = 3;
  localparam int BIT_FOUR_BYTE = 2;
  localparam int BIT_PARITY = 1;
  localparam int BIT_AUTOLOAD_INH = 0;
  localparam int BIT_EURO_CART = 0;
  localparam logic [7:0] FLAGS_USED_MASK = 8'hAF;
  localparam logic [7:0] REGION_USED_MASK = 8'h01;
  // ----------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------
  localparam logic [7:0] MOTION_THR_RST = 8'h80;
  localparam logic [7:0] RECONN_THR_RST = 8'hA0;
  localparam logic [7:0] GAP_THR_RST = 8'h07;
  localparam logic [7:0] THR_MIN = 8'h20;
  localparam logic [7:0] THR_MAX = 8'hD0;
  localparam logic [7:0] GAP_THR_MAX = 8'h07;
  localparam logic [7:0] HOLD_RECONN_THR = 8'hA0;
  // one threshold count is one kilobyte
  localparam int KB_SHIFT = 10;
  localparam int FILL_W = 18;
  localparam int LEN_W = 24;
  localparam logic [LEN_W-1:0] HOLD_MAX_LEN = 24'h02_8000;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam logic [3:0] GAP_ONE = 4'h1;
  localparam logic [1:0] WORD_ALIGN_MASK = 2'h3;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CART_DOMESTIC = 2'h0,
    CART_EUROPEAN = 2'h1,
    CART_INTL_MIXED = 2'h2
  } cart_kind_type;
  typedef enum logic [1:0] {
    CMD_IDLE = 2'b00,
    CMD_HOLD = 2'b01,
    CMD_GO = 2'b11
  } cmd_state_type;
endpackage

/* File: hw/kb_threshold_cmp.sv */
// module: buffer fill against a kilobyte threshold
`timescale 1ns/100ps
module kb_threshold_cmp (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // compare inputs
  input wire logic [7:0] thr_kb,
  input wire logic [tape_opt_pkg::FILL_W-1:0] level,
  // compare results
  output logic at_or_above_r,
  output logic at_or_below_r
);
  import tape_opt_pkg::*;

  logic [FILL_W-1:0] thr_bytes;

  // scale the kilobyte count to bytes
  always_comb begin
    thr_bytes = FILL_W'({thr_kb, {KB_SHIFT{1'b0}}});
  end

  // registered comparisons
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      at_or_above_r <= 1'b0;
      at_or_below_r <= 1'b0;
    end else begin
      at_or_above_r <= (level >= thr_bytes);
      at_or_below_r <= (level <= thr_bytes);
    end
  end
endmodule // kb_threshold_cmp

/* File: hw/tape_drive_option_parameters.sv */
// module: drive option parameters and the logic they steer
// What this block does
// - cartridge and european bits pick autosizing type
// - cartridge type writable loaded or unloaded
// - hold connection caps transfers at 160 KB
// - hold connection: write waits for free space
// - hold connection: read waits for all data
// - busy suppression bit, default reports busy
// - suppressed busy holds command, status after motion
// - rewind-early and diagnostics still report busy
// - busy reported, bus released until reissue
// - read-ahead or flush queues without busy
// - four-byte disconnect alignment bit, default off
// - parity check bit, default off
// - autoload inhibit bit, powers up off
// - motion threshold default 80h, 20h to D0h
// - motion starts at threshold fill or drain
// - reconnect threshold default A0h, 20h to D0h
// - reconnect after threshold drained or filled
// - hold connection forces reconnect to 160 KB
// - gap threshold clamps at 07h, counts gaps
`timescale 1ns/100ps
module tape_drive_option_parameters (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // parameter byte port
  input wire logic param_wr_en,
  input wire logic [2:0] param_wr_index,
  input wire logic [7:0] param_wr_data,
  input wire logic [2:0] param_rd_index,
  output logic [7:0] param_rd_data_r,
  // switch pins
  input wire logic sw_cart_region,
  input wire logic sw_busy_suppression,
  input wire logic sw_four_byte,
  input wire logic sw_parity_check,
  // cartridge and motion pins
  input wire logic cart_inserted,
  // command status from the drive
  input wire logic cmd_arrive,
  input wire logic drive_busy,
  input wire logic read_ahead_active,
  input wire logic write_flush_active,
  input wire logic rewind_immed_active,
  input wire logic diag_active,
  input wire logic tape_moving,
  input wire logic rw_done,
  // transfer request
  input wire logic xfer_req,
  input wire logic xfer_is_write,
  input wire logic [tape_opt_pkg::LEN_W-1:0] xfer_len,
  // buffer state
  input wire logic [tape_opt_pkg::FILL_W-1:0] buf_fill,
  input wire logic [tape_opt_pkg::FILL_W-1:0] buf_free,
  input wire logic [tape_opt_pkg::FILL_W-1:0] buf_drained,
  input wire logic disconnected,
  // bus byte stream
  input wire logic bus_byte_valid,
  input wire logic [7:0] bus_byte,
  input wire logic bus_parity,
  input wire logic [1:0] bus_byte_count,
  // gap writing
  input wire logic gap_block_written,
  input wire logic data_block_written,
  input wire logic track_end,
  // option state
  output tape_opt_pkg::cart_kind_type cart_kind_r,
  output logic hold_connection_mode_r,
  output logic four_byte_disconnect_r,
  output logic parity_check_enable_r,
  output logic autoload_inhibit_r,
  // command handling
  output logic report_busy_r,
  output logic release_bus_r,
  output logic cmd_accept_r,
  output logic cmd_held_r,
  output logic rw_status_ok_r,
  // transfer gating
  output logic xfer_len_err_r,
  output logic xfer_start_r,
  // motion and bus control
  output logic motion_start_r,
  output logic reconnect_r,
  output logic disconnect_ok_r,
  output logic parity_err_r,
  output logic load_cartridge_r,
  output logic gap_stop_r
);
  import tape_opt_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_meta_r;
  logic [4:0] pin_sync_r;
  logic [1:0] settle_r;
  logic straps_done_r;
  logic cart_seen_r;

  // two flops on every pin
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= {cart_inserted, sw_parity_check, sw_four_byte,
                     sw_busy_suppression, sw_cart_region};
      pin_sync_r <= pin_meta_r;
    end
  end

  // wait for synchronised straps after reset release
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_r <= '0;
      straps_done_r <= 1'b0;
    end else if (!straps_done_r) begin
      settle_r <= settle_r + 2'h1;
      straps_done_r <= (settle_r == STRAP_SETTLE);
    end
  end

  // ----------------------------------------------------------------
  // option registers
  // ----------------------------------------------------------------
  logic [7:0] flags_r;
  logic [7:0] region_r;
  logic [7:0] motion_thr_r;
  logic [7:0] reconn_thr_r;
  logic [7:0] gap_thr_r;
  logic strap_load;

  assign strap_load = (settle_r == STRAP_SETTLE) && !straps_done_r;

  // bound a threshold write to the legal range
  function automatic logic [7:0] clamp_thr(input logic [7:0] v);
    if (v < THR_MIN) begin
      clamp_thr = THR_MIN;
    end else if (v > THR_MAX) begin
      clamp_thr = THR_MAX;
    end else begin
      clamp_thr = v;
    end
  endfunction

  // flag byte and region byte
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_r <= '0;
      region_r <= '0;
    end else if (strap_load) begin
      flags_r[BIT_BUSY_SUPP] <= pin_sync_r[1];
      flags_r[BIT_FOUR_BYTE] <= pin_sync_r[2];
      flags_r[BIT_PARITY] <= pin_sync_r[3];
      region_r[BIT_EURO_CART] <= pin_sync_r[0];
    end else if (param_wr_en) begin
      if (param_wr_index == OFS_OPTION_FLAGS) begin
        flags_r <= param_wr_data & FLAGS_USED_MASK;
      end
      if (param_wr_index == OFS_REGION_SEL) begin
        region_r <= param_wr_data & REGION_USED_MASK;
      end
    end
  end

  // threshold bytes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      motion_thr_r <= MOTION_THR_RST;
      reconn_thr_r <= RECONN_THR_RST;
      gap_thr_r <= GAP_THR_RST;
    end else if (param_wr_en) begin
      if (param_wr_index == OFS_MOTION_THR) begin
        motion_thr_r <= clamp_thr(param_wr_data);
      end
      if (param_wr_index == OFS_RECONN_THR && !flags_r[BIT_HOLD_CONN]) begin
        reconn_thr_r <= clamp_thr(param_wr_data);
      end
      if (param_wr_index == OFS_GAP_THR) begin
        gap_thr_r <= param_wr_data;
      end
    end
  end

  // readback of the parameter bytes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      param_rd_data_r <= '0;
    end else begin
      case (param_rd_index)
        OFS_OPTION_FLAGS: param_rd_data_r <= flags_r;
        OFS_REGION_SEL: param_rd_data_r <= region_r;
        OFS_MOTION_THR: param_rd_data_r <= motion_thr_r;
        OFS_RECONN_THR: param_rd_data_r <= reconn_thr_r;
        OFS_GAP_THR: param_rd_data_r <= gap_thr_r;
        default: param_rd_data_r <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // decoded options
  // ----------------------------------------------------------------
  logic hold_mode;
  logic busy_supp;
  logic [7:0] reconn_eff;

  assign hold_mode = flags_r[BIT_HOLD_CONN];
  assign busy_supp = flags_r[BIT_BUSY_SUPP];
  assign reconn_eff = hold_mode ? HOLD_RECONN_THR : reconn_thr_r;

  // option outputs
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cart_kind_r <= CART_DOMESTIC;
      hold_connection_mode_r <= 1'b0;
      four_byte_disconnect_r <= 1'b0;
      parity_check_enable_r <= 1'b0;
      autoload_inhibit_r <= 1'b0;
    end else begin
      if (flags_r[BIT_CART_TYPE]) begin
        cart_kind_r <= CART_INTL_MIXED;
      end else if (region_r[BIT_EURO_CART]) begin
        cart_kind_r <= CART_EUROPEAN;
      end else begin
        cart_kind_r <= CART_DOMESTIC;
      end
      hold_connection_mode_r <= hold_mode;
      four_byte_disconnect_r <= flags_r[BIT_FOUR_BYTE];
      parity_check_enable_r <= flags_r[BIT_PARITY];
      autoload_inhibit_r <= flags_r[BIT_AUTOLOAD_INH];
    end
  end

  // ----------------------------------------------------------------
  // command arrival and busy handling
  // ----------------------------------------------------------------
  cmd_state_type cmd_state_r;
  logic hard_busy;
  logic soft_busy;

  assign hard_busy = rewind_immed_active || diag_active;
  assign soft_busy = drive_busy || read_ahead_active || write_flush_active;

  // command state machine
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_state_r <= CMD_IDLE;
      report_busy_r <= 1'b0;
      release_bus_r <= 1'b0;
      cmd_accept_r <= 1'b0;
    end else begin
      report_busy_r <= 1'b0;
      release_bus_r <= 1'b0;
      cmd_accept_r <= 1'b0;
      case (cmd_state_r)
        CMD_IDLE: begin
          if (cmd_arrive) begin
            if (hard_busy) begin
              report_busy_r <= 1'b1;
              release_bus_r <= 1'b1;
            end else if (read_ahead_active || write_flush_active) begin
              cmd_state_r <= CMD_HOLD;
            end else if (drive_busy && !busy_supp) begin
              report_busy_r <= 1'b1;
              release_bus_r <= 1'b1;
            end else if (drive_busy) begin
              cmd_state_r <= CMD_HOLD;
            end else begin
              cmd_state_r <= CMD_GO;
            end
          end
        end
        CMD_HOLD: begin
          if (!soft_busy && !hard_busy && !tape_moving) begin
            cmd_state_r <= CMD_GO;
          end
        end
        CMD_GO: begin
          cmd_accept_r <= 1'b1;
          cmd_state_r <= CMD_IDLE;
        end
        default: cmd_state_r <= CMD_IDLE;
      endcase
    end
  end

  // held flag and ending status release
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_held_r <= 1'b0;
      rw_status_ok_r <= 1'b0;
    end else begin
      cmd_held_r <= (cmd_state_r == CMD_HOLD);
      rw_status_ok_r <= rw_done && (!busy_supp || !tape_moving);
    end
  end

  // ----------------------------------------------------------------
  // hold connection transfer gating
  // ----------------------------------------------------------------
  logic xfer_pend_r;
  logic pend_write_r;
  logic [LEN_W-1:0] pend_len_r;
  logic len_fits;

  assign len_fits = (pend_len_r <= LEN_W'(buf_free)) || !pend_write_r;

  // capture a request and release it when room or data is there
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      xfer_pend_r <= 1'b0;
      pend_write_r <= 1'b0;
      pend_len_r <= '0;
      xfer_len_err_r <= 1'b0;
      xfer_start_r <= 1'b0;
    end else begin
      xfer_len_err_r <= 1'b0;
      xfer_start_r <= 1'b0;
      if (xfer_req) begin
        if (hold_mode && xfer_len > HOLD_MAX_LEN) begin
          xfer_len_err_r <= 1'b1;
        end else if (!hold_mode) begin
          xfer_start_r <= 1'b1;
        end else begin
          xfer_pend_r <= 1'b1;
          pend_write_r <= xfer_is_write;
          pend_len_r <= xfer_len;
        end
      end else if (xfer_pend_r) begin
        if (pend_write_r && len_fits) begin
          xfer_pend_r <= 1'b0;
          xfer_start_r <= 1'b1;
        end
        if (!pend_write_r && pend_len_r <= LEN_W'(buf_fill)) begin
          xfer_pend_r <= 1'b0;
          xfer_start_r <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // motion and reconnect thresholds
  // ----------------------------------------------------------------
  logic fill_ge_motion;
  logic fill_le_motion;
  logic fill_ge_reconn;
  logic drain_ge_reconn;

  kb_threshold_cmp u_motion_cmp (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .thr_kb(motion_thr_r),
    .level(buf_fill),
    .at_or_above_r(fill_ge_motion),
    .at_or_below_r(fill_le_motion)
  );

  kb_threshold_cmp u_reconn_fill_cmp (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .thr_kb(reconn_eff),
    .level(buf_fill),
    .at_or_above_r(fill_ge_reconn),
    .at_or_below_r()
  );

  kb_threshold_cmp u_reconn_drain_cmp (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .thr_kb(reconn_eff),
    .level(buf_drained),
    .at_or_above_r(drain_ge_reconn),
    .at_or_below_r()
  );

  // start motion and reconnect decisions
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      motion_start_r <= 1'b0;
      reconnect_r <= 1'b0;
    end else begin
      // write fills up, read drains down
      motion_start_r <= !tape_moving &&
                        (xfer_is_write ? fill_ge_motion : fill_le_motion);
      reconnect_r <= disconnected &&
                     (xfer_is_write ? drain_ge_reconn : fill_ge_reconn);
    end
  end

  // ----------------------------------------------------------------
  // bus byte checks and autoload
  // ----------------------------------------------------------------
  // disconnect points, parity and insertion edge
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      disconnect_ok_r <= 1'b1;
      parity_err_r <= 1'b0;
      load_cartridge_r <= 1'b0;
      cart_seen_r <= 1'b0;
    end else begin
      disconnect_ok_r <= !flags_r[BIT_FOUR_BYTE] ||
                         ((bus_byte_count & WORD_ALIGN_MASK) == 2'h0);
      parity_err_r <= bus_byte_valid && flags_r[BIT_PARITY] &&
                      ((^bus_byte) == bus_parity);
      cart_seen_r <= pin_sync_r[4];
      load_cartridge_r <= pin_sync_r[4] && !cart_seen_r &&
                          !flags_r[BIT_AUTOLOAD_INH];
    end
  end

  // ----------------------------------------------------------------
  // gap block limit
  // ----------------------------------------------------------------
  logic [3:0] gap_count_r;
  logic [3:0] gap_limit;

  assign gap_limit = (gap_thr_r > GAP_THR_MAX) ? 4'(GAP_THR_MAX) + GAP_ONE :
                     4'(gap_thr_r) + GAP_ONE;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_count_r <= '0;
      gap_stop_r <= 1'b0;
    end else begin
      gap_stop_r <= 1'b0;
      if (data_block_written) begin
        gap_count_r <= '0;
      end else if (gap_thr_r == 8'h00) begin
        gap_stop_r <= track_end;
      end else if (gap_block_written) begin
        if (gap_count_r + GAP_ONE >= gap_limit) begin
          gap_stop_r <= 1'b1;
          gap_count_r <= '0;
        end else begin
          gap_count_r <= gap_count_r + GAP_ONE;
        end
      end
    end
  end
endmodule // tape_drive_option_parameters

/* File: dv/tdop_asserts.sv */
// checker: timing relations at the option parameter block's ports
`timescale 1ns/100ps
module tdop_asserts (
  // watched ports
  input wire logic sys_clk, reset_n, cmd_arrive, drive_busy, rewind_immed_active, diag_active,
  input wire logic report_busy_r, release_bus_r, xfer_req, hold_connection_mode_r, xfer_len_err_r,
  input wire logic xfer_start_r, bus_byte_valid, bus_parity, parity_check_enable_r, parity_err_r,
  input wire logic cart_inserted, autoload_inhibit_r, load_cartridge_r, gap_block_written, track_end,
  input wire logic gap_stop_r, tape_moving, motion_start_r, disconnected, reconnect_r,
  input wire logic [7:0] bus_byte,
  input wire logic [tape_opt_pkg::LEN_W-1:0] xfer_len
);
  import tape_opt_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_busy_frees_bus: assert property (report_busy_r |-> release_bus_r && $past(cmd_arrive))
    else $error("busy answer without bus release");
  a_busy_has_cause: assert property (report_busy_r |-> $past(drive_busy) ||
    $past(rewind_immed_active) || $past(diag_active)) else $error("busy with no busy source");
  a_len_cap: assert property (xfer_req && hold_connection_mode_r && xfer_len > HOLD_MAX_LEN
    |=> xfer_len_err_r && !xfer_start_r) else $error("long transfer not refused");
  a_free_start: assert property (xfer_req && !hold_connection_mode_r |=> xfer_start_r)
    else $error("transfer without hold mode did not start");
  a_err_cause: assert property (xfer_len_err_r |-> $past(xfer_req) && $past(hold_connection_mode_r))
    else $error("length error without request");
  a_parity_flag: assert property (bus_byte_valid && parity_check_enable_r && (^bus_byte == bus_parity)
    |=> parity_err_r) else $error("parity fault missed");
  a_parity_cause: assert property (parity_err_r |-> $past(bus_byte_valid) && $past(parity_check_enable_r))
    else $error("parity fault while disabled");
  a_autoload_go: assert property ($rose(cart_inserted) && !autoload_inhibit_r |-> ##[2:4] load_cartridge_r)
    else $error("no load on insertion");
  a_autoload_held: assert property ($rose(cart_inserted) && autoload_inhibit_r |-> !load_cartridge_r [*5])
    else $error("load while inhibited");
  a_gap_cause: assert property (gap_stop_r |-> $past(gap_block_written) || $past(track_end))
    else $error("gap stop without gap block");
  a_moving_no_start: assert property (tape_moving |=> !motion_start_r)
    else $error("motion start while moving");
  a_reconnect_on_bus: assert property (!disconnected |=> !reconnect_r)
    else $error("reconnect while connected");
endmodule // tdop_asserts
bind tape_drive_option_parameters tdop_asserts tdop_asserts_inst (.*);

/* File: dv/host_model.sv */
// initiator model: parameter bytes, commands and transfer requests
`timescale 1ns/100ps
module host_model (
  // clock
  input wire logic sys_clk,
  // requests
  output logic param_wr_en, cmd_arrive, xfer_req, xfer_is_write,
  output logic [2:0] param_wr_index,
  output logic [7:0] param_wr_data,
  output logic [tape_opt_pkg::LEN_W-1:0] xfer_len
);
  // idle levels at time zero
  initial begin
    {param_wr_en, cmd_arrive, xfer_req, xfer_is_write} = '0;
    param_wr_index = '0;
    param_wr_data = '0;
    xfer_len = '0;
  end
  // one byte write, data inverted once released
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    @(negedge sys_clk);
    param_wr_en = 1'h1;
    param_wr_index = i;
    param_wr_data = d;
    @(negedge sys_clk);
    param_wr_en = 1'h0;
    param_wr_data = ~d;
  endtask
  task automatic euro_only(input logic [7:0] f);
    wr(3'h0, f & 8'h7F);
    wr(3'h1, 8'h01);
  endtask
  task automatic thresholds(input logic [7:0] m, r, g);
    wr(3'h2, m);
    wr(3'h3, r);
    wr(3'h4, g);
  endtask
  task automatic command();
    @(negedge sys_clk);
    cmd_arrive = 1'h1;
    @(negedge sys_clk);
    cmd_arrive = 1'h0;
  endtask
  task automatic xfer(input logic w, input logic [23:0] n);
    @(negedge sys_clk);
    xfer_req = 1'h1;
    xfer_is_write = w;
    xfer_len = n;
    @(negedge sys_clk);
    xfer_req = 1'h0;
  endtask
endmodule // host_model

/* File: dv/tb.sv */
// testbench: option parameter block
`timescale 1ns/100ps
module tb;
  import tape_opt_pkg::*;
  logic sys_clk = '0, reset_n = '0, sw_cart_region = '0, sw_busy_suppression = '0, sw_four_byte = '0;
  logic sw_parity_check = '0, cart_inserted = '0, drive_busy = '0, read_ahead_active = '0;
  logic write_flush_active = '0, rewind_immed_active = '0, diag_active = '0, tape_moving = '0;
  logic rw_done = '0, disconnected = '0, bus_byte_valid = '0, bus_parity = '0, track_end = '0;
  logic gap_block_written = '0, data_block_written = '0;
  logic [2:0] param_rd_index = '0;
  logic [7:0] bus_byte = '0, seen = '0;
  logic [1:0] bus_byte_count = '0;
  logic [FILL_W-1:0] buf_fill = '0, buf_free = '0, buf_drained = '0;
  logic param_wr_en, cmd_arrive, xfer_req, xfer_is_write;
  logic [2:0] param_wr_index;
  logic [7:0] param_wr_data, param_rd_data_r;
  logic [LEN_W-1:0] xfer_len;
  cart_kind_type cart_kind_r;
  logic hold_connection_mode_r, four_byte_disconnect_r, parity_check_enable_r, autoload_inhibit_r;
  logic report_busy_r, release_bus_r, cmd_accept_r, cmd_held_r, rw_status_ok_r, xfer_len_err_r;
  logic xfer_start_r, motion_start_r, reconnect_r, disconnect_ok_r, parity_err_r, load_cartridge_r;
  logic gap_stop_r;
  int bad_count = 0, checks = 0;
  host_model host_model_inst (.*);
  tape_drive_option_parameters tape_drive_option_parameters_inst (.*);
  always #50 sys_clk = ~sys_clk;
  // sticky record of output pulses
  always @(posedge sys_clk) seen <= seen | {gap_stop_r, load_cartridge_r, parity_err_r, cmd_accept_r,
    report_busy_r, xfer_len_err_r, xfer_start_r, cmd_held_r};
  task automatic cmp(input logic [7:0] g, e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic clr;
    @(negedge sys_clk);
    seen = '0;
  endtask
  task automatic rd(input logic [2:0] i, input logic [7:0] e);
    @(negedge sys_clk);
    param_rd_index = i;
    wt(2);
    cmp(param_rd_data_r, e);
  endtask
  task automatic gaps(input int n, input logic e);
    clr;
    repeat (n) begin
      @(negedge sys_clk) gap_block_written = 1'h1;
      @(negedge sys_clk) gap_block_written = 1'h0;
    end
    wt(2);
    cmp(seen[7], e);
  endtask
  task automatic cmd_exp(input logic [1:0] e);
    clr;
    host_model_inst.command();
    wt(3);
    cmp({seen[3], cmd_held_r}, e);
  endtask
  task automatic par(input logic p, e);
    clr;
    bus_byte_valid = 1'h1;
    bus_byte = 8'h01;
    bus_parity = p;
    @(negedge sys_clk) bus_byte_valid = 1'h0;
    bus_byte = 8'hFE;
    wt(2);
    cmp(seen[5], e);
  endtask
  task automatic lvl(input logic [FILL_W-1:0] v, input logic e);
    buf_fill = v;
    buf_drained = v;
    wt(3);
    cmp(disconnected ? reconnect_r : motion_start_r, e);
  endtask
  task automatic t_regs;
    rd(3'h0, 8'h00);
    rd(3'h2, 8'h80);
    rd(3'h3, 8'hA0);
    rd(3'h4, 8'h07);
    rd(3'h5, 8'h00);
    host_model_inst.wr(3'h2, 8'h10);
    rd(3'h2, 8'h20);
    host_model_inst.wr(3'h3, 8'hFF);
    rd(3'h3, 8'hD0);
    host_model_inst.wr(3'h4, 8'h1F);
    gaps(7, 1'h0);
    gaps(1, 1'h1);
  endtask
  task automatic t_flags;
    host_model_inst.wr(3'h0, 8'hFF);
    rd(3'h0, 8'hAF);
    cmp({hold_connection_mode_r, four_byte_disconnect_r, parity_check_enable_r, autoload_inhibit_r}, 4'hF);
    host_model_inst.wr(3'h1, 8'hFF);
    rd(3'h1, 8'h01);
    cmp(cart_kind_r, CART_INTL_MIXED);
    bus_byte_count = 2'h1;
    cart_inserted = 1'h1;
    wt(6);
    cmp(disconnect_ok_r, 1'h0);
    host_model_inst.euro_only(8'h00);
    wt(3);
    cmp({cart_kind_r, disconnect_ok_r}, {CART_EUROPEAN, 1'h1});
    host_model_inst.wr(3'h1, 8'h00);
    wt(2);
    cmp(cart_kind_r, CART_DOMESTIC);
    cart_inserted = 1'h0;
  endtask
  task automatic t_hold;
    host_model_inst.wr(3'h0, 8'h20);
    host_model_inst.wr(3'h3, 8'h40);
    rd(3'h3, 8'hD0);
    clr;
    host_model_inst.xfer(1'h1, 24'h02_8001);
    wt(2);
    cmp(seen[2:1], 2'h2);
    buf_free = 18'h0_00FF;
    host_model_inst.xfer(1'h1, 24'h00_0100);
    wt(4);
    cmp(seen[1], 1'h0);
    buf_free = 18'h0_0100;
    wt(3);
    cmp(seen[1], 1'h1);
    clr;
    buf_fill = 18'h0_00FF;
    host_model_inst.xfer(1'h0, 24'h00_0100);
    wt(4);
    cmp(seen[2:1], 2'h0);
    lvl(18'h0_0100, 1'h1);
    cmp(seen[1], 1'h1);
    disconnected = 1'h1;
    lvl(18'h2_7FFF, 1'h0);
    lvl(18'h2_8000, 1'h1);
    disconnected = 1'h0;
  endtask
  task automatic t_motion;
    host_model_inst.wr(3'h0, 8'h00);
    host_model_inst.thresholds(8'h20, 8'h20, 8'h00);
    host_model_inst.xfer(1'h1, 24'h00_0001);
    lvl(18'h0_7FFF, 1'h0);
    lvl(18'h0_8000, 1'h1);
    disconnected = 1'h1;
    lvl(18'h0_7FFF, 1'h0);
    lvl(18'h0_8000, 1'h1);
    disconnected = 1'h0;
    clr;
    track_end = 1'h1;
    @(negedge sys_clk) track_end = 1'h0;
    wt(2);
    cmp(seen[7], 1'h1);
  endtask
  task automatic t_busy;
    drive_busy = 1'h1;
    cmd_exp(2'h2);
    host_model_inst.wr(3'h0, 8'h08);
    cmd_exp(2'h1);
    drive_busy = 1'h0;
    wt(4);
    cmp(seen[4], 1'h1);
    rw_done = 1'h1;
    tape_moving = 1'h1;
    wt(3);
    cmp(rw_status_ok_r, 1'h0);
    tape_moving = 1'h0;
    wt(3);
    cmp(rw_status_ok_r, 1'h1);
    rw_done = 1'h0;
    diag_active = 1'h1;
    cmd_exp(2'h2);
    diag_active = 1'h0;
    rewind_immed_active = 1'h1;
    cmd_exp(2'h2);
    rewind_immed_active = 1'h0;
    host_model_inst.wr(3'h0, 8'h00);
    write_flush_active = 1'h1;
    read_ahead_active = 1'h1;
    cmd_exp(2'h1);
    {write_flush_active, read_ahead_active} = 2'h0;
    wt(4);
    cmp(seen[4], 1'h1);
  endtask
  task automatic t_misc;
    host_model_inst.wr(3'h0, 8'h02);
    par(1'h1, 1'h1);
    par(1'h0, 1'h0);
    host_model_inst.wr(3'h0, 8'h00);
    par(1'h1, 1'h0);
    clr;
    cart_inserted = 1'h1;
    wt(6);
    cmp(seen[6], 1'h1);
    cart_inserted = 1'h0;
    host_model_inst.wr(3'h0, 8'h01);
    clr;
    cart_inserted = 1'h1;
    wt(6);
    cmp(seen[6], 1'h0);
  endtask
  task automatic tally_and_finish;
    if (bad_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk) reset_n = 1'h1;
    wt(6);
    t_regs;
    t_flags;
    t_hold;
    t_motion;
    t_busy;
    t_misc;
    tally_and_finish;
  end
endmodule // tb
